// *** inc/ssw_consts.vh ***
`ifndef SSW_CONSTS_VH
`define SSW_CONSTS_VH

// --------------------------------------
// clock and timing
// --------------------------------------
`define SSW_CLK_KHZ 100000
`define SSW_RED_PERIOD_MS 1000
`define SSW_GREEN_PERIOD_MS 2000
`define SSW_GAP_MS 2000
`define SSW_TONE_PERIOD_US 500
`define SSW_RED_HALF_CYC (`SSW_CLK_KHZ * `SSW_RED_PERIOD_MS / 2)
`define SSW_GREEN_HALF_CYC (`SSW_CLK_KHZ * `SSW_GREEN_PERIOD_MS / 2)
`define SSW_GAP_CYC (`SSW_CLK_KHZ * `SSW_GAP_MS)
`define SSW_TONE_HALF_CYC (`SSW_CLK_KHZ * `SSW_TONE_PERIOD_US / 2000)
`define SSW_BEEP_GROUPS 3'h5

// --------------------------------------
// power state codes
// --------------------------------------
`define SSW_PS_S0 3'h0
`define SSW_PS_S1 3'h1
`define SSW_PS_S3 3'h3
`define SSW_PS_S4 3'h4
`define SSW_PS_S5 3'h5

// --------------------------------------
// fault codes (value equals flash count)
// --------------------------------------
`define SSW_FLT_NONE 4'h0
`define SSW_FLT_MIN 4'h2
`define SSW_FLT_MAX 4'ha
`define SSW_FLT_NOBEEP 4'ha

// --------------------------------------
// wake source bit positions
// --------------------------------------
`define SSW_WK_PWRBTN 0
`define SSW_WK_RTC 1
`define SSW_WK_LAN 2
`define SSW_WK_PME 3
`define SSW_WK_RING 4
`define SSW_WK_USB 5
`define SSW_WK_KBD 6
`define SSW_WK_MOUSE 7
`define SSW_WK_WIDTH 8
`define SSW_WK_SOFTOFF_MASK 8'h1f

// --------------------------------------
// fan levels and temperature thresholds
// --------------------------------------
`define SSW_FAN_OFF 2'h0
`define SSW_FAN_LOW 2'h1
`define SSW_FAN_MED 2'h2
`define SSW_FAN_HIGH 2'h3
`define SSW_TEMP_MED 8'h3c
`define SSW_TEMP_HIGH 8'h4b
`define SSW_TEMP_HYST 8'h03

`endif

// *** rtl/ssw_sync.v ***
`timescale 1ns/1ps
`include "ssw_consts.vh"

module ssw_sync #(
    parameter WIDTH = 1
) (
    input wire ref_clk,                 // system clock
    input wire reset,                   // synchronous, active high
    input wire [WIDTH-1:0] async_in,    // pin level from outside the domain
    output wire [WIDTH-1:0] sync_out    // qualified level
);

    // ------------------------------------------------------------------------
    // three-stage synchroniser per bit
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_ff;
            reg stage2_ff;
            reg stage3_ff;
            reg out_ff;
            // the first stage feeds only the second; a change is accepted once
            // stages two and three agree, which also drops one-cycle glitches
            always @(posedge ref_clk)
            begin
                if (reset)
                begin
                    meta_ff <= 1'b0;
                    stage2_ff <= 1'b0;
                    stage3_ff <= 1'b0;
                    out_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= async_in[i];
                    stage2_ff <= meta_ff;
                    stage3_ff <= stage2_ff;
                    if (stage2_ff == stage3_ff)
                        out_ff <= stage3_ff;
                end
            end
            assign sync_out[i] = out_ff;
        end
    endgenerate

endmodule // ssw_sync

// *** rtl/ssw_fan.v ***
`timescale 1ns/1ps
`include "ssw_consts.vh"

module ssw_fan #(
    parameter [7:0] TEMP_MED = `SSW_TEMP_MED,
    parameter [7:0] TEMP_HIGH = `SSW_TEMP_HIGH,
    parameter [7:0] TEMP_HYST = `SSW_TEMP_HYST
) (
    input wire ref_clk,            // system clock
    input wire reset,              // synchronous, active high
    input wire sleeping,           // system in a sleep state
    input wire proc_hot,           // processor hot, synchronised
    input wire psu_hot,            // power supply hot, synchronised
    input wire [7:0] cpu_temp,     // sensed processor temperature
    output wire [1:0] fan_level    // commanded fan speed
);

    reg [1:0] fan_level_ff;
    reg [1:0] up_level;
    reg [1:0] down_level;
    reg [1:0] nxt_fan_level;

    // ------------------------------------------------------------------------
    // speed selection
    // ------------------------------------------------------------------------
    // up and down thresholds differ by the hysteresis so the fan does not
    // hunt between two speeds when the temperature sits on a threshold
    always @*
    begin
        up_level = (cpu_temp >= TEMP_HIGH) ? `SSW_FAN_HIGH :
                   (cpu_temp >= TEMP_MED) ? `SSW_FAN_MED : `SSW_FAN_LOW;
        down_level = (cpu_temp >= TEMP_HIGH - TEMP_HYST) ? `SSW_FAN_HIGH :
                     (cpu_temp >= TEMP_MED - TEMP_HYST) ? `SSW_FAN_MED : `SSW_FAN_LOW;
        nxt_fan_level = fan_level_ff;
        if (up_level > fan_level_ff)
            nxt_fan_level = up_level;
        else if (down_level < fan_level_ff)
            nxt_fan_level = down_level;
        if (proc_hot)
            nxt_fan_level = `SSW_FAN_HIGH;
        if (sleeping && !proc_hot && !psu_hot)
            nxt_fan_level = `SSW_FAN_OFF;
    end

    always @(posedge ref_clk)
    begin
        if (reset)
            fan_level_ff <= `SSW_FAN_LOW;
        else
            fan_level_ff <= nxt_fan_level;
    end

    assign fan_level = fan_level_ff;

endmodule // ssw_fan

// *** rtl/ssw_top.v ***
`timescale 1ns/1ps
`include "ssw_consts.vh"

// Overview of operation
// - steady green in S0, dark in S4/S5
// - green blinks at 0.5 Hz in S1/S3
// - fault: red flashes code count at 1 Hz
// - two and a half second dark gap, then group repeats
// - beeps match flashes, none for code ten
// - beeps for five groups, then only flashing
// - wake sources qualified by suspend or soft-off
// - low fan normally, faster when processor hot
// - fans stop asleep, restart when overheating
// - slowest fan speed that keeps temperature proper
module ssw_top #(
    parameter [31:0] RED_HALF_CYC = `SSW_RED_HALF_CYC,
    parameter [31:0] GREEN_HALF_CYC = `SSW_GREEN_HALF_CYC,
    parameter [31:0] GAP_CYC = `SSW_GAP_CYC,
    parameter [31:0] TONE_HALF_CYC = `SSW_TONE_HALF_CYC,
    parameter [7:0] TEMP_MED = `SSW_TEMP_MED,
    parameter [7:0] TEMP_HIGH = `SSW_TEMP_HIGH,
    parameter [7:0] TEMP_HYST = `SSW_TEMP_HYST
) (
    input wire ref_clk,                         // 100 MHz system clock
    input wire reset,                           // synchronous, active high
    input wire [2:0] power_state,               // current sleep state code
    input wire [3:0] fault_code,                // active fault, 0 when none
    input wire [`SSW_WK_WIDTH-1:0] wake_src,    // wake source pins
    input wire proc_hot_in,                     // processor hot pin
    input wire psu_hot_in,                      // power supply hot pin
    input wire [7:0] cpu_temp,                  // sensed processor temperature
    output wire led_green,                      // power led green element
    output wire led_red,                        // power led red element
    output wire speaker,                        // chassis speaker drive
    output wire wake_req,                       // wake the system
    output wire [1:0] fan_level                 // fan speed command
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    localparam [1:0] ST_STATUS = 2'h0;
    localparam [1:0] ST_RED_ON = 2'h1;
    localparam [1:0] ST_RED_OFF = 2'h2;
    localparam [1:0] ST_GAP = 2'h3;

    wire [`SSW_WK_WIDTH+1:0] pins_sync;
    wire [`SSW_WK_WIDTH-1:0] wake_sync;
    wire proc_hot;
    wire psu_hot;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [31:0] timer_ff;
    reg [31:0] nxt_timer;
    reg [3:0] flash_ff;
    reg [3:0] nxt_flash;
    reg [3:0] code_ff;
    reg [3:0] nxt_code;
    reg [2:0] groups_ff;
    reg [2:0] nxt_groups;

    reg [31:0] green_timer_ff;
    reg green_phase_ff;
    reg [31:0] tone_timer_ff;
    reg tone_ff;

    reg led_green_ff;
    reg led_red_ff;
    reg speaker_ff;
    reg wake_req_ff;

    wire fault_now;
    wire blinking;
    wire green_lit;
    wire beep_active;
    wire suspended;
    wire soft_off;

    // ------------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------------
    // a code outside 2..10 is treated as no fault so the led never shows a
    // count that means nothing
    function is_fault;
        input [3:0] code;
        begin
            is_fault = (code >= `SSW_FLT_MIN) && (code <= `SSW_FLT_MAX);
        end
    endfunction

    function is_blink_state;
        input [2:0] ps;
        begin
            is_blink_state = (ps == `SSW_PS_S1) || (ps == `SSW_PS_S3);
        end
    endfunction

    assign fault_now = is_fault(fault_code);
    assign blinking = is_blink_state(power_state);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    ssw_sync #(
        .WIDTH(`SSW_WK_WIDTH + 2)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({psu_hot_in, proc_hot_in, wake_src}),
        .sync_out(pins_sync)
    );

    assign wake_sync = pins_sync[`SSW_WK_WIDTH-1:0];
    assign proc_hot = pins_sync[`SSW_WK_WIDTH];
    assign psu_hot = pins_sync[`SSW_WK_WIDTH+1];

    // ------------------------------------------------------------------------
    // fault flash sequencer
    // ------------------------------------------------------------------------
    // the code is latched at the start of each group so a change to another code in 2..10 mid-group
    // never produces a truncated or mixed count; it takes effect after the gap
    always @*
    begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_flash = flash_ff;
        nxt_code = code_ff;
        nxt_groups = groups_ff;
        case (state_ff)
            ST_STATUS:
            begin
                nxt_timer = 32'h0;
                nxt_flash = 4'h0;
                if (fault_now)
                begin
                    nxt_state = ST_RED_ON;
                    nxt_code = fault_code;
                    nxt_groups = 3'h0;
                end
            end
            ST_RED_ON:
            begin
                nxt_timer = timer_ff + 32'h1;
                if (!fault_now)
                    nxt_state = ST_STATUS;
                else if (timer_ff >= RED_HALF_CYC - 32'h1)
                begin
                    nxt_state = ST_RED_OFF;
                    nxt_timer = 32'h0;
                    nxt_flash = flash_ff + 4'h1;
                end
            end
            ST_RED_OFF:
            begin
                nxt_timer = timer_ff + 32'h1;
                if (!fault_now)
                    nxt_state = ST_STATUS;
                else if (timer_ff >= RED_HALF_CYC - 32'h1)
                begin
                    nxt_timer = 32'h0;
                    if (flash_ff >= code_ff)
                    begin
                        nxt_state = ST_GAP;
                        if (groups_ff < `SSW_BEEP_GROUPS)
                            nxt_groups = groups_ff + 3'h1;
                    end
                    else
                        nxt_state = ST_RED_ON;
                end
            end
            ST_GAP:
            begin
                nxt_timer = timer_ff + 32'h1;
                if (!fault_now)
                    nxt_state = ST_STATUS;
                else if (timer_ff >= GAP_CYC - 32'h1)
                begin
                    nxt_state = ST_RED_ON;
                    nxt_timer = 32'h0;
                    nxt_flash = 4'h0;
                    if (fault_code != code_ff)
                    begin
                        nxt_code = fault_code;
                        nxt_groups = 3'h0;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_STATUS;
                nxt_timer = 32'h0;
                nxt_flash = 4'h0;
            end
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_ff <= ST_STATUS;
            timer_ff <= 32'h0;
            flash_ff <= 4'h0;
            code_ff <= `SSW_FLT_NONE;
            groups_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            flash_ff <= nxt_flash;
            code_ff <= nxt_code;
            groups_ff <= nxt_groups;
        end
    end

    // ------------------------------------------------------------------------
    // green blink timer
    // ------------------------------------------------------------------------
    // held in reset outside S1/S3 so every blink sequence starts lit
    always @(posedge ref_clk)
    begin
        if (reset || !blinking)
        begin
            green_timer_ff <= 32'h0;
            green_phase_ff <= 1'b0;
        end
        else if (green_timer_ff >= GREEN_HALF_CYC - 32'h1)
        begin
            green_timer_ff <= 32'h0;
            green_phase_ff <= ~green_phase_ff;
        end
        else
            green_timer_ff <= green_timer_ff + 32'h1;
    end

    assign green_lit = (power_state == `SSW_PS_S0) ||
                       (blinking && !green_phase_ff);

    // ------------------------------------------------------------------------
    // speaker tone
    // ------------------------------------------------------------------------
    // beeps ride on the red on-time, so the count matches the flashes except for code ten and after five groups
    assign beep_active = (state_ff == ST_RED_ON) &&
                         (code_ff != `SSW_FLT_NOBEEP) &&
                         (groups_ff < `SSW_BEEP_GROUPS);

    always @(posedge ref_clk)
    begin
        if (reset || !beep_active)
        begin
            tone_timer_ff <= 32'h0;
            tone_ff <= 1'b0;
        end
        else if (tone_timer_ff >= TONE_HALF_CYC - 32'h1)
        begin
            tone_timer_ff <= 32'h0;
            tone_ff <= ~tone_ff;
        end
        else
            tone_timer_ff <= tone_timer_ff + 32'h1;
    end

    // ------------------------------------------------------------------------
    // wake qualification
    // ------------------------------------------------------------------------
    // usb, keyboard and mouse are masked out in soft-off since their
    // controllers are unpowered there and would only give false wakes
    assign suspended = (power_state == `SSW_PS_S1) ||
                       (power_state == `SSW_PS_S3) ||
                       (power_state == `SSW_PS_S4);
    assign soft_off = (power_state == `SSW_PS_S5);

    // ------------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------------
    // red takes the led over whenever a fault runs, green is forced off
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            led_green_ff <= 1'b0;
            led_red_ff <= 1'b0;
            speaker_ff <= 1'b0;
            wake_req_ff <= 1'b0;
        end
        else
        begin
            led_red_ff <= (state_ff == ST_RED_ON);
            led_green_ff <= (state_ff == ST_STATUS) && green_lit;
            speaker_ff <= beep_active && tone_ff;
            wake_req_ff <= (suspended && (|wake_sync)) ||
                           (soft_off && (|(wake_sync & `SSW_WK_SOFTOFF_MASK)));
        end
    end

    assign led_green = led_green_ff;
    assign led_red = led_red_ff;
    assign speaker = speaker_ff;
    assign wake_req = wake_req_ff;

    // ------------------------------------------------------------------------
    // fan control
    // ------------------------------------------------------------------------
    ssw_fan #(
        .TEMP_MED(TEMP_MED),
        .TEMP_HIGH(TEMP_HIGH),
        .TEMP_HYST(TEMP_HYST)
    ) u_fan (
        .ref_clk(ref_clk),
        .reset(reset),
        .sleeping(suspended),
        .proc_hot(proc_hot),
        .psu_hot(psu_hot),
        .cpu_temp(cpu_temp),
        .fan_level(fan_level)
    );

endmodule // ssw_top

// *** sim/ssw_top_props.sv ***
`timescale 1ns/1ps
// --------------------------------------
// port checker
// --------------------------------------
module ssw_top_props #(
    parameter [31:0] RED_HALF_CYC = 32'h8,
    parameter [7:0] TEMP_MED = 8'h3c,
    parameter [7:0] TEMP_HYST = 8'h03
) (
    input wire ref_clk, // system clock
    input wire reset, // synchronous, active high
    input wire [2:0] power_state, // sleep state code
    input wire [3:0] fault_code, // active fault code
    input wire [7:0] wake_src, // wake pins
    input wire proc_hot_in, // processor hot pin
    input wire psu_hot_in, // supply hot pin
    input wire [7:0] cpu_temp, // processor temperature
    input wire led_green, // green element
    input wire led_red, // red element
    input wire speaker, // speaker drive
    input wire wake_req, // wake request
    input wire [1:0] fan_level // fan command
);
    reg [31:0] red_run_ff;
    wire [31:0] nxt_red_run;
    wire flt_valid;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // red on-run length, so the on-time needs no long repetition
    assign flt_valid = (fault_code >= 4'h2) && (fault_code <= 4'ha);
    assign nxt_red_run = led_red ? red_run_ff + 32'h1 : 32'h0;
    always @(posedge ref_clk)
    begin
        red_run_ff <= reset ? 32'h0 : nxt_red_run;
    end

    // seven samples span the pin qualifier and output register
    sequence s_s0_quiet; (power_state == 3'h0 && !flt_valid)[*4]; endsequence
    sequence s_off_quiet; ((power_state == 3'h4 || power_state == 3'h5) && !flt_valid)[*4]; endsequence
    sequence s_softoff_idle; (power_state == 3'h5 && wake_src[4:0] == 5'h0)[*7]; endsequence
    sequence s_usb_suspend; (power_state == 3'h3 && wake_src[5])[*7]; endsequence
    sequence s_asleep_cool; (power_state == 3'h3 && !proc_hot_in && !psu_hot_in)[*7]; endsequence
    sequence s_proc_hot; proc_hot_in[*7]; endsequence
    sequence s_awake_cool; (power_state == 3'h0 && !proc_hot_in && cpu_temp < TEMP_MED - TEMP_HYST)[*7]; endsequence

    a_never_both: assert property (!(led_green && led_red))
        else $error("red with green");
    a_green_steady: assert property (s_s0_quiet |-> led_green)
        else $error("green not steady");
    a_dark_off: assert property (s_off_quiet |-> !led_green && !led_red)
        else $error("led lit in s4/s5");
    a_red_on_width: assert property ($fell(led_red) && flt_valid |-> red_run_ff == RED_HALF_CYC)
        else $error("red flash on-time wrong");
    a_beep_with_red: assert property (speaker |-> led_red)
        else $error("beep outside red");
    a_wake_s0_none: assert property (power_state == 3'h0 |=> !wake_req)
        else $error("wake in s0");
    a_softoff_mask: assert property (s_softoff_idle |=> !wake_req)
        else $error("bad soft-off wake");
    a_suspend_wake: assert property (s_usb_suspend |=> wake_req)
        else $error("no usb wake");
    a_fan_sleep_off: assert property (s_asleep_cool |=> fan_level == 2'h0)
        else $error("fans on while asleep");
    a_fan_proc_hot: assert property (s_proc_hot |=> fan_level == 2'h3)
        else $error("no fan raise when hot");
    a_fan_cool_low: assert property (s_awake_cool |=> fan_level == 2'h1)
        else $error("fan not low when cool");
endmodule // ssw_top_props

// *** sim/ssw_indicator_model.sv ***
`timescale 1ns/1ps
// --------------------------------------
// led and speaker model, grouping red flashes
// --------------------------------------
module ssw_indicator_model #(
    parameter int RED_HALF_CYC = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic led_red, // red element
    input wire logic speaker, // speaker drive
    output int last_flashes, // flashes in last full group
    output int last_beeps, // beeping flashes in last group
    output int last_gap, // dark cycles before the group that closed it
    output int grp_cnt // groups closed so far
);
    int dark_ff, flash_ff, beep_ff;
    logic red_ff, spk_seen_ff;

    // a dark run longer than one off-half closes a group; empty groups are not reported
    always @(posedge ref_clk)
    begin
        red_ff <= reset ? 1'b0 : led_red;
        if (reset)
        begin
            dark_ff <= 0; flash_ff <= 0; beep_ff <= 0; spk_seen_ff <= 1'b0; grp_cnt <= 0;
        end
        else if (led_red)
        begin
            dark_ff <= 0;
            if (speaker)
                spk_seen_ff <= 1'b1;
            if (!red_ff && dark_ff > RED_HALF_CYC && flash_ff != 0)
            begin
                last_flashes <= flash_ff; last_beeps <= beep_ff; last_gap <= dark_ff;
                grp_cnt <= grp_cnt + 1; flash_ff <= 1; beep_ff <= 0;
            end
            else if (!red_ff)
                flash_ff <= (dark_ff > RED_HALF_CYC) ? 1 : flash_ff + 1;
        end
        else
        begin
            dark_ff <= dark_ff + 1;
            if (red_ff)
                beep_ff <= beep_ff + (spk_seen_ff ? 1 : 0);
            spk_seen_ff <= 1'b0;
        end
    end
endmodule // ssw_indicator_model

// *** sim/ssw_top_tb.sv ***
`timescale 1ns/1ps
`include "ssw_consts.vh"
module ssw_top_tb;
    localparam int RED = 8;
    localparam int GAP = 20;
    logic ref_clk = 1'b0, reset = 1'b1, proc_hot_in = 1'b0, psu_hot_in = 1'b0;
    logic [2:0] power_state = `SSW_PS_S0;
    logic [3:0] fault_code = `SSW_FLT_NONE;
    logic [7:0] wake_src = 8'h00, cpu_temp = 8'h30;
    wire led_green, led_red, speaker, wake_req;
    wire [1:0] fan_level;
    int last_flashes, last_beeps, last_gap, grp_cnt;
    int fails = 0, num_checks = 0;

    // ----------------------------------
    // clock, design and far side
    // ----------------------------------
    always #5 ref_clk = ~ref_clk;
    ssw_top #(.RED_HALF_CYC(32'h8), .GREEN_HALF_CYC(32'h8), .GAP_CYC(32'h14), .TONE_HALF_CYC(32'h2)) DUT (
        .ref_clk(ref_clk), .reset(reset), .power_state(power_state), .fault_code(fault_code),
        .wake_src(wake_src), .proc_hot_in(proc_hot_in), .psu_hot_in(psu_hot_in), .cpu_temp(cpu_temp),
        .led_green(led_green), .led_red(led_red), .speaker(speaker), .wake_req(wake_req),
        .fan_level(fan_level));
    ssw_indicator_model #(.RED_HALF_CYC(RED)) led_far (
        .ref_clk(ref_clk), .reset(reset), .led_red(led_red), .speaker(speaker),
        .last_flashes(last_flashes), .last_beeps(last_beeps), .last_gap(last_gap), .grp_cnt(grp_cnt));

    // ----------------------------------
    // shared tasks; inputs change and outputs are sampled at the falling edge
    // ----------------------------------
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic give_verdict;
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // bounded: a silent led never closes a group
    task automatic wait_groups(input int k);
        int g0;
        int n;
        g0 = grp_cnt;
        n = 0;
        while (grp_cnt < g0 + k && n < 3000)
        begin
            tick(1);
            n++;
        end
        check("group reached", 32'(grp_cnt >= g0 + k), 1);
    endtask

    // ----------------------------------
    // scenarios
    // ----------------------------------
    task automatic test_states;
        int n;
        power_state = `SSW_PS_S0; tick(6);
        check("green in s0", 32'(led_green), 1);
        power_state = `SSW_PS_S4; tick(4);
        check("led in s4", 32'({led_green, led_red}), 0);
        power_state = `SSW_PS_S5; tick(4);
        check("led in s5", 32'({led_green, led_red}), 0);
        for (int i = 0; i < 2; i++)
        begin
            power_state = `SSW_PS_S0; tick(4);
            power_state = (i == 0) ? `SSW_PS_S1 : `SSW_PS_S3;
            n = 0;
            while (led_green !== 1'b0 && n < 40) begin tick(1); n++; end
            n = 0;
            while (led_green === 1'b0 && n < 40) begin tick(1); n++; end
            check("green dark half", n, 8);
            n = 0;
            while (led_green === 1'b1 && n < 40) begin tick(1); n++; end
            check("green lit half", n, 8);
            check("sleep beep or red", 32'({speaker, led_red}), 0);
        end
        power_state = `SSW_PS_S0;
    endtask
    // a code's first report may hold the aborted group's tail
    task automatic test_faults;
        for (int c = 2; c <= 10; c++)
        begin
            fault_code = 4'(c);
            wait_groups(2);
            check("flash count", last_flashes, c);
            check("beep count", last_beeps, (c == 10) ? 0 : c);
            check("dark gap", last_gap, RED + GAP);
            fault_code = `SSW_FLT_NONE; tick(6);
            check("red after abort", 32'(led_red), 0);
        end
    endtask
    // report g here covers group g + 1
    task automatic test_beep_limit;
        fault_code = 4'h3;
        wait_groups(1);
        for (int g = 1; g <= 7; g++)
        begin
            wait_groups(1);
            check("beeps in group", last_beeps, (g <= 4) ? 3 : 0);
            check("flashes go on", last_flashes, 3);
        end
        fault_code = `SSW_FLT_NONE; tick(6);
    endtask
    task automatic test_wake;
        logic [2:0] states [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
        logic exp;
        foreach (states[s])
        begin
            power_state = states[s];
            for (int b = 0; b < 8; b++)
            begin
                wake_src = 8'h01 << b; tick(8);
                exp = (s >= 1 && s <= 3) || (s == 4 && b < 5);
                check("wake request", 32'(wake_req), 32'(exp));
                wake_src = 8'h00; tick(8);
            end
        end
        power_state = `SSW_PS_S0;
    endtask
    task automatic fan_step(input logic [2:0] ps, input logic [7:0] t, input logic [1:0] hot, input logic [1:0] exp);
        power_state = ps; cpu_temp = t; {proc_hot_in, psu_hot_in} = hot; tick(8);
        check("fan level", 32'(fan_level), 32'(exp));
    endtask
    task automatic test_fan;
        fan_step(`SSW_PS_S0, 8'h30, 2'h0, `SSW_FAN_LOW);
        fan_step(`SSW_PS_S0, 8'h3c, 2'h0, `SSW_FAN_MED);
        fan_step(`SSW_PS_S0, 8'h4b, 2'h0, `SSW_FAN_HIGH);
        fan_step(`SSW_PS_S0, 8'h49, 2'h0, `SSW_FAN_HIGH);
        fan_step(`SSW_PS_S0, 8'h47, 2'h0, `SSW_FAN_MED);
        fan_step(`SSW_PS_S0, 8'h30, 2'h2, `SSW_FAN_HIGH);
        fan_step(`SSW_PS_S3, 8'h30, 2'h0, `SSW_FAN_OFF);
        fan_step(`SSW_PS_S3, 8'h30, 2'h1, `SSW_FAN_LOW);
        fan_step(`SSW_PS_S3, 8'h30, 2'h2, `SSW_FAN_HIGH);
        fan_step(`SSW_PS_S0, 8'h30, 2'h0, `SSW_FAN_LOW);
    endtask

    // ----------------------------------
    // main sequence; watchdog far above the cycles needed
    // ----------------------------------
    initial
    begin
        tick(20);
        check("reset outputs", 32'({led_green, led_red, speaker, wake_req, fan_level}), 1);
        reset = 1'b0;
        tick(4);
        test_states;
        test_faults;
        test_beep_limit;
        test_wake;
        test_fan;
        give_verdict;
    end
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        fails++;
        give_verdict;
    end
endmodule // ssw_top_tb

bind ssw_top ssw_top_props #(.RED_HALF_CYC(RED_HALF_CYC), .TEMP_MED(TEMP_MED), .TEMP_HYST(TEMP_HYST)) u_props (
    .ref_clk(ref_clk), .reset(reset), .power_state(power_state), .fault_code(fault_code),
    .wake_src(wake_src), .proc_hot_in(proc_hot_in), .psu_hot_in(psu_hot_in), .cpu_temp(cpu_temp),
    .led_green(led_green), .led_red(led_red), .speaker(speaker), .wake_req(wake_req),
    .fan_level(fan_level));
